// file: rtl/iex_datapath.sv
// Integer execute datapath: register ALU, shifts, multiply/divide into the
// upper/bottom special pair, and jump/branch target and link formation.
// Assumes the decoder offers one operation per cycle with i_valid, holds it
// while o_ready is low, and the fetch unit applies o_redirect after the
// instruction that follows the transfer.
//
// Function
// - Trapping add/subtract give 32-bit sum/difference
// - Trapping forms raise exception on overflow
// - Non-trapping forms wrap, never raise exception
// - Set-if-less writes 1/0, signed or unsigned
// - AND, OR, XOR, NOR across all bits
// - Fixed left shift of source_b, zero fill
// - Fixed logical right shift, zero fill
// - Fixed arithmetic right shift, sign fill
// - Variable shifts use low 5 bits of source_a
// - Products place 64 bits in upper/bottom
// - Quotient to bottom, remainder to upper
// - Read upper/bottom into destination register
// - Write general register into upper/bottom
// - Delay slot always executes after a transfer
// - Absolute target: PC top 4, field shifted
// - Absolute call links after-slot address to 31
// - Register transfer jumps to source_a address
// - Register call links after-slot address to destination
// - Branch target uses 16-bit PC-relative offset
// - Branch target: slot address plus scaled offset
`timescale 1ns/1ps
`default_nettype none

module iex_datapath #(
    parameter int unsigned DATA_W = 32
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_valid,
    input wire iex_pkg::iex_op_t i_op,
    input wire logic [DATA_W-1:0] i_source_a,
    input wire logic [DATA_W-1:0] i_source_b,
    input wire logic [iex_pkg::REG_IDX_W-1:0] i_dest,
    input wire logic [iex_pkg::SHAMT_W-1:0] i_shift_count,
    input wire logic [iex_pkg::JUMP_FIELD_W-1:0] i_jump_field,
    input wire logic [iex_pkg::OFFSET_W-1:0] i_offset,
    input wire logic i_branch_taken,
    input wire logic [DATA_W-1:0] i_pc,
    output logic o_ready,
    output logic o_wr_en,
    output logic [iex_pkg::REG_IDX_W-1:0] o_wr_addr,
    output logic [DATA_W-1:0] o_wr_data,
    output logic o_overflow_trap,
    output logic o_redirect,
    output logic [DATA_W-1:0] o_target,
    output logic [DATA_W-1:0] o_muldiv_upper,
    output logic [DATA_W-1:0] o_muldiv_bottom
);
    import iex_pkg::*;

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    iex_state_t state;
    logic take;
    logic [DATA_W-1:0] upper;
    logic [DATA_W-1:0] bottom;
    logic [DATA_W:0] sum_wide;
    logic [DATA_W:0] diff_wide;
    logic sum_ovf;
    logic diff_ovf;
    logic [SHAMT_W-1:0] var_count;
    logic [DATA_W-1:0] alu_out;
    logic alu_writes;
    logic [2*DATA_W-1:0] prod_u;
    logic signed [2*DATA_W-1:0] prod_s;
    logic [DATA_W-1:0] slot_addr;
    logic [DATA_W-1:0] link_addr;
    logic [DATA_W-1:0] branch_disp;
    logic [DATA_W-1:0] next_target;
    logic next_redirect;
    logic [DATA_W-1:0] div_rem;
    logic [DATA_W-1:0] div_quo;
    logic [DATA_W-1:0] div_den;
    logic [5:0] div_cnt;
    logic div_neg_q;
    logic div_neg_r;
    logic [DATA_W:0] div_trial;
    logic [DATA_W-1:0] div_rem_sh;
    logic [DATA_W-1:0] abs_a;
    logic [DATA_W-1:0] abs_b;
    logic div_start;

    assign o_ready = (state == ST_IDLE);
    assign take = i_valid && o_ready;
    assign o_muldiv_upper = upper;
    assign o_muldiv_bottom = bottom;

    // -------------------------------------------------------------------
    // Arithmetic, compare, logic and shifts
    // -------------------------------------------------------------------
    assign sum_wide = {1'b0, i_source_a} + {1'b0, i_source_b};
    assign diff_wide = {1'b0, i_source_a} - {1'b0, i_source_b};
    // Overflow: operand signs agree (sum) or clash (difference) and the result leaves source_a
    assign sum_ovf = (i_source_a[DATA_W-1] == i_source_b[DATA_W-1])
        && (sum_wide[DATA_W-1] != i_source_a[DATA_W-1]);
    assign diff_ovf = (i_source_a[DATA_W-1] != i_source_b[DATA_W-1])
        && (diff_wide[DATA_W-1] != i_source_a[DATA_W-1]);
    assign var_count = i_source_a[SHAMT_W-1:0];

    always_comb begin
        alu_out = WORD_RESET;
        alu_writes = 1'b1;
        unique case (i_op)
            OP_SUM_TRAP, OP_SUM_NO_TRAP: begin
                alu_out = sum_wide[DATA_W-1:0];
            end
            OP_DIFF_TRAP, OP_DIFF_NO_TRAP: begin
                alu_out = diff_wide[DATA_W-1:0];
            end
            OP_SET_IF_LESS_SIGNED: begin
                alu_out = {{(DATA_W-1){1'b0}},
                    ($signed(i_source_a) < $signed(i_source_b))};
            end
            OP_SET_IF_BELOW_UNSIGNED: begin
                alu_out = {{(DATA_W-1){1'b0}},
                    (i_source_a < i_source_b)};
            end
            OP_AND: begin
                alu_out = i_source_a & i_source_b;
            end
            OP_OR: begin
                alu_out = i_source_a | i_source_b;
            end
            OP_XOR: begin
                alu_out = i_source_a ^ i_source_b;
            end
            OP_NOR: begin
                alu_out = ~(i_source_a | i_source_b);
            end
            OP_SHIFT_LEFT_FIXED: begin
                alu_out = i_source_b << i_shift_count;
            end
            OP_SHIFT_RIGHT_ZERO_FIXED: begin
                alu_out = i_source_b >> i_shift_count;
            end
            OP_SHIFT_RIGHT_SIGN_FIXED: begin
                alu_out = DATA_W'($signed(i_source_b) >>>
                    i_shift_count);
            end
            OP_SHIFT_LEFT_VAR: begin
                alu_out = i_source_b << var_count;
            end
            OP_SHIFT_RIGHT_ZERO_VAR: begin
                alu_out = i_source_b >> var_count;
            end
            OP_SHIFT_RIGHT_SIGN_VAR: begin
                alu_out = DATA_W'($signed(i_source_b) >>>
                    var_count);
            end
            OP_READ_UPPER: begin
                alu_out = upper;
            end
            OP_READ_BOTTOM: begin
                alu_out = bottom;
            end
            OP_CALL_ABSOLUTE_LINK, OP_CALL_VIA_REGISTER, OP_BRANCH_LINK: begin
                alu_out = link_addr;
            end
            default: alu_writes = 1'b0;
        endcase
    end

    // -------------------------------------------------------------------
    // Transfer targets
    // -------------------------------------------------------------------
    assign slot_addr = i_pc + SLOT_STEP;
    assign link_addr = i_pc + LINK_STEP;
    assign branch_disp = {{(DATA_W-OFFSET_W-WORD_SHIFT)
        {i_offset[OFFSET_W-1]}}, i_offset, {WORD_SHIFT{1'b0}}};

    always_comb begin
        next_target = WORD_RESET;
        next_redirect = 1'b0;
        unique case (i_op)
            OP_JUMP_ABSOLUTE, OP_CALL_ABSOLUTE_LINK: begin
                next_target = {i_pc[DATA_W-1 -: PC_TOP_W], i_jump_field,
                    {WORD_SHIFT{1'b0}}};
                next_redirect = 1'b1;
            end
            OP_TRANSFER_VIA_REGISTER, OP_CALL_VIA_REGISTER: begin
                next_target = i_source_a;
                next_redirect = 1'b1;
            end
            OP_BRANCH, OP_BRANCH_LINK: begin
                next_target = slot_addr + branch_disp;
                next_redirect = i_branch_taken;
            end
            default: next_redirect = 1'b0;
        endcase
    end

    // Redirect is a one-cycle pulse; fetch keeps the slot instruction
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_redirect <= 1'b0;
            o_target <= WORD_RESET;
        end else begin
            o_redirect <= take && next_redirect;
            if (take && next_redirect) begin
                o_target <= next_target;
            end
        end
    end

    // -------------------------------------------------------------------
    // Register file write-back and overflow exception
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wr_en <= 1'b0;
            o_wr_addr <= LINK_REG_IDX;
            o_wr_data <= WORD_RESET;
            o_overflow_trap <= 1'b0;
        end else begin
            o_overflow_trap <= take
                && (((i_op == OP_SUM_TRAP) && sum_ovf)
                || ((i_op == OP_DIFF_TRAP) && diff_ovf));
            // A trapping overflow leaves the destination untouched
            o_wr_en <= take && alu_writes
                && !((i_op == OP_SUM_TRAP) && sum_ovf)
                && !((i_op == OP_DIFF_TRAP) && diff_ovf);
            if (take && alu_writes) begin
                o_wr_data <= alu_out;
                o_wr_addr <= (i_op == OP_CALL_ABSOLUTE_LINK
                    || i_op == OP_BRANCH_LINK)
                    ? LINK_REG_IDX : i_dest;
            end
        end
    end

    // -------------------------------------------------------------------
    // Multiply and the special register pair
    // -------------------------------------------------------------------
    assign prod_u = {{DATA_W{1'b0}}, i_source_a}
        * {{DATA_W{1'b0}}, i_source_b};
    assign prod_s = $signed({{DATA_W{i_source_a[DATA_W-1]}}, i_source_a})
        * $signed({{DATA_W{i_source_b[DATA_W-1]}}, i_source_b});
    assign abs_a = (i_op == OP_SIGNED_QUOTIENT && i_source_a[DATA_W-1])
        ? (-i_source_a) : i_source_a;
    assign abs_b = (i_op == OP_SIGNED_QUOTIENT && i_source_b[DATA_W-1])
        ? (-i_source_b) : i_source_b;
    assign div_start = take && (i_op == OP_SIGNED_QUOTIENT
        || i_op == OP_UNSIGNED_QUOTIENT);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            upper <= WORD_RESET;
            bottom <= WORD_RESET;
        end else if (state == ST_DIVIDE && div_cnt == DIV_CNT_RESET) begin
            bottom <= div_neg_q ? (-div_quo) : div_quo;
            upper <= div_neg_r ? (-div_rem) : div_rem;
        end else if (take) begin
            unique case (i_op)
                OP_SIGNED_PRODUCT: begin
                    upper <= prod_s[2*DATA_W-1:DATA_W];
                    bottom <= prod_s[DATA_W-1:0];
                end
                OP_UNSIGNED_PRODUCT: begin
                    upper <= prod_u[2*DATA_W-1:DATA_W];
                    bottom <= prod_u[DATA_W-1:0];
                end
                OP_WRITE_UPPER: begin
                    upper <= i_source_a;
                end
                OP_WRITE_BOTTOM: begin
                    bottom <= i_source_a;
                end
                default: upper <= upper;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Restoring divider, one quotient bit per cycle
    // -------------------------------------------------------------------
    assign div_rem_sh = {div_rem[DATA_W-2:0], div_quo[DATA_W-1]};
    assign div_trial = {div_rem[DATA_W-1], div_rem_sh} - {1'b0, div_den};

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (div_start) begin
                        state <= ST_DIVIDE;
                    end
                end
                ST_DIVIDE: begin
                    if (div_cnt == DIV_CNT_RESET) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_rem <= WORD_RESET;
            div_quo <= WORD_RESET;
            div_den <= WORD_RESET;
            div_cnt <= DIV_CNT_RESET;
            div_neg_q <= 1'b0;
            div_neg_r <= 1'b0;
        end else if (div_start) begin
            div_rem <= WORD_RESET;
            div_quo <= abs_a;
            div_den <= abs_b;
            div_cnt <= 6'(DIV_STEPS);
            div_neg_q <= (i_op == OP_SIGNED_QUOTIENT)
                && (i_source_a[DATA_W-1] != i_source_b[DATA_W-1]);
            div_neg_r <= (i_op == OP_SIGNED_QUOTIENT)
                && i_source_a[DATA_W-1];
        end else if (state == ST_DIVIDE && div_cnt != DIV_CNT_RESET) begin
            div_cnt <= div_cnt - 6'h01;
            if (!div_trial[DATA_W]) begin
                div_rem <= div_trial[DATA_W-1:0];
                div_quo <= {div_quo[DATA_W-2:0], 1'b1};
            end else begin
                div_rem <= div_rem_sh;
                div_quo <= {div_quo[DATA_W-2:0], 1'b0};
            end
        end
    end

endmodule

`default_nettype wire

// file: rtl/iex_pkg.sv
// Constants, operation codes and states of the integer execute datapath.
// Assumes a decoder that maps instructions onto iex_op_t.
package iex_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned SHAMT_W = 5;
    localparam int unsigned REG_IDX_W = 5;
    localparam int unsigned JUMP_FIELD_W = 26;
    localparam int unsigned OFFSET_W = 16;
    localparam int unsigned PC_TOP_W = 4;
    localparam int unsigned WORD_SHIFT = 2;
    localparam int unsigned DIV_STEPS = 32;
    localparam logic [REG_IDX_W-1:0] LINK_REG_IDX = 5'h1f;
    localparam logic [DATA_W-1:0] SLOT_STEP = 32'h0000_0004;
    localparam logic [DATA_W-1:0] LINK_STEP = 32'h0000_0008;
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
    localparam logic [5:0] DIV_CNT_RESET = 6'h00;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_SUM_TRAP = 5'h01,
        OP_SUM_NO_TRAP = 5'h02,
        OP_DIFF_TRAP = 5'h03,
        OP_DIFF_NO_TRAP = 5'h04,
        OP_SET_IF_LESS_SIGNED = 5'h05,
        OP_SET_IF_BELOW_UNSIGNED = 5'h06,
        OP_AND = 5'h07,
        OP_OR = 5'h08,
        OP_XOR = 5'h09,
        OP_NOR = 5'h0a,
        OP_SHIFT_LEFT_FIXED = 5'h0b,
        OP_SHIFT_RIGHT_ZERO_FIXED = 5'h0c,
        OP_SHIFT_RIGHT_SIGN_FIXED = 5'h0d,
        OP_SHIFT_LEFT_VAR = 5'h0e,
        OP_SHIFT_RIGHT_ZERO_VAR = 5'h0f,
        OP_SHIFT_RIGHT_SIGN_VAR = 5'h10,
        OP_SIGNED_PRODUCT = 5'h11,
        OP_UNSIGNED_PRODUCT = 5'h12,
        OP_SIGNED_QUOTIENT = 5'h13,
        OP_UNSIGNED_QUOTIENT = 5'h14,
        OP_READ_UPPER = 5'h15,
        OP_READ_BOTTOM = 5'h16,
        OP_WRITE_UPPER = 5'h17,
        OP_WRITE_BOTTOM = 5'h18,
        OP_JUMP_ABSOLUTE = 5'h19,
        OP_CALL_ABSOLUTE_LINK = 5'h1a,
        OP_TRANSFER_VIA_REGISTER = 5'h1b,
        OP_CALL_VIA_REGISTER = 5'h1c,
        OP_BRANCH = 5'h1d,
        OP_BRANCH_LINK = 5'h1e
    } iex_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DIVIDE = 2'b10
    } iex_state_t;

endpackage

// file: sim/iex_datapath_asserts.sv
// Concurrent checks on the ports of the integer execute datapath.
// Assumes one core clock and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module iex_datapath_asserts
    import iex_pkg::*;
#(
    parameter int unsigned DATA_W = 32
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_valid,
    input wire iex_pkg::iex_op_t i_op,
    input wire logic [DATA_W-1:0] i_source_a,
    input wire logic [DATA_W-1:0] i_source_b,
    input wire logic [iex_pkg::REG_IDX_W-1:0] i_dest,
    input wire logic [iex_pkg::SHAMT_W-1:0] i_shift_count,
    input wire logic [iex_pkg::JUMP_FIELD_W-1:0] i_jump_field,
    input wire logic [iex_pkg::OFFSET_W-1:0] i_offset,
    input wire logic i_branch_taken,
    input wire logic [DATA_W-1:0] i_pc,
    input wire logic o_ready,
    input wire logic o_wr_en,
    input wire logic [iex_pkg::REG_IDX_W-1:0] o_wr_addr,
    input wire logic [DATA_W-1:0] o_wr_data,
    input wire logic o_overflow_trap,
    input wire logic o_redirect,
    input wire logic [DATA_W-1:0] o_target,
    input wire logic [DATA_W-1:0] o_muldiv_upper,
    input wire logic [DATA_W-1:0] o_muldiv_bottom
);
    // ----------------------------------------
    // Reference values
    // ----------------------------------------
    logic take;
    logic ovf;
    logic lt_s;
    logic [31:0] sum;
    logic [31:0] abs_tgt;
    logic [31:0] br_tgt;
    logic [31:0] sra_v;
    logic [63:0] prod_s;
    assign take = i_valid && o_ready;
    assign sum = i_source_a + i_source_b;
    assign ovf = (i_source_a[31] == i_source_b[31])
        && (sum[31] != i_source_a[31]);
    assign lt_s = $signed(i_source_a) < $signed(i_source_b);
    assign abs_tgt = {i_pc[31:28], i_jump_field, 2'b00};
    assign br_tgt = i_pc + 32'h4 + {{14{i_offset[15]}}, i_offset, 2'b00};
    assign sra_v = 32'($signed(i_source_b) >>> i_source_a[4:0]);
    assign prod_s = {{32{i_source_a[31]}}, i_source_a} *
        {{32{i_source_b[31]}}, i_source_b};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_trap_raised: assert property (
        take && i_op == OP_SUM_TRAP && ovf |=> o_overflow_trap && !o_wr_en
    ) else $error("overflow not trapped");
    a_sum_wraps: assert property (
        take && i_op == OP_SUM_NO_TRAP
        |=> o_wr_en && !o_overflow_trap && o_wr_data == $past(sum)
    ) else $error("wrapping sum wrong");
    a_less_signed: assert property (
        take && i_op == OP_SET_IF_LESS_SIGNED
        |=> o_wr_en && o_wr_data == {31'h0, $past(lt_s)}
    ) else $error("signed compare wrong");
    a_var_shift: assert property (
        take && i_op == OP_SHIFT_RIGHT_SIGN_VAR |=> o_wr_data == $past(sra_v)
    ) else $error("variable shift wrong");
    a_product_pair: assert property (
        take && i_op == OP_SIGNED_PRODUCT
        |=> {o_muldiv_upper, o_muldiv_bottom} == $past(prod_s)
    ) else $error("signed product wrong");
    a_divide_busy: assert property (
        take && i_op inside {OP_SIGNED_QUOTIENT, OP_UNSIGNED_QUOTIENT}
        |=> !o_ready ##32 !o_ready ##1 o_ready
    ) else $error("divide busy span wrong");
    a_pair_holds: assert property (
        o_ready && !(take && i_op inside {OP_SIGNED_PRODUCT,
        OP_UNSIGNED_PRODUCT, OP_SIGNED_QUOTIENT, OP_UNSIGNED_QUOTIENT,
        OP_WRITE_UPPER, OP_WRITE_BOTTOM})
        |=> $stable(o_muldiv_upper) && $stable(o_muldiv_bottom)
    ) else $error("special pair changed");
    a_abs_call: assert property (
        take && i_op == OP_CALL_ABSOLUTE_LINK
        |=> o_redirect && o_target == $past(abs_tgt) && o_wr_en &&
        o_wr_addr == LINK_REG_IDX && o_wr_data == $past(i_pc) + LINK_STEP
    ) else $error("absolute call wrong");
    a_reg_call: assert property (
        take && i_op == OP_CALL_VIA_REGISTER
        |=> o_redirect && o_target == $past(i_source_a) &&
        o_wr_addr == $past(i_dest) && o_wr_data == $past(i_pc) + LINK_STEP
    ) else $error("register call wrong");
    a_branch_target: assert property (
        take && i_op == OP_BRANCH && i_branch_taken
        |=> o_redirect && o_target == $past(br_tgt)
    ) else $error("branch target wrong");

    c_divide: cover property (take && i_op == OP_UNSIGNED_QUOTIENT);
    c_trap: cover property (o_overflow_trap);
    c_link: cover property (o_redirect && o_wr_en);
endmodule

bind iex_datapath iex_datapath_asserts #(.DATA_W(DATA_W)) u_asserts (
    .i_clk, .i_arst_n, .i_valid, .i_op, .i_source_a, .i_source_b, .i_dest,
    .i_shift_count, .i_jump_field, .i_offset, .i_branch_taken, .i_pc,
    .o_ready, .o_wr_en, .o_wr_addr, .o_wr_data, .o_overflow_trap,
    .o_redirect, .o_target, .o_muldiv_upper, .o_muldiv_bottom
);
`default_nettype wire

// file: sim/iex_regfile_model.sv
// General register file standing behind the datapath's write port.
// Assumes one-cycle write enables on the core clock.
`timescale 1ns/1ps
`default_nettype none
module iex_regfile_model (
    input wire logic i_clk,
    input wire logic i_wr_en,
    input wire logic [4:0] i_wr_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic [4:0] i_rd_idx,
    output logic [31:0] o_rd_data
);
    logic [31:0] regs [32];
    always @(posedge i_clk) begin
        if (i_wr_en) begin
            regs[i_wr_addr] <= i_wr_data;
        end
    end
    assign o_rd_data = regs[i_rd_idx];
endmodule
`default_nettype wire

// file: sim/tb_integer_execute_datapath.sv
// Self-checking bench for the integer execute datapath.
// Assumes the design, its package and the register file model are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_integer_execute_datapath;
    import iex_pkg::*;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_valid = 1'b0;
    logic i_branch_taken = 1'b0;
    iex_op_t i_op = OP_NONE;
    logic [31:0] i_source_a = '0;
    logic [31:0] i_source_b = '0;
    logic [31:0] i_pc = '0;
    logic [4:0] i_dest = 5'h0a;
    logic [4:0] i_shift_count = 5'h1f;
    logic [25:0] i_jump_field = '0;
    logic [15:0] i_offset = '0;
    logic o_ready, o_wr_en, o_overflow_trap, o_redirect;
    logic [4:0] o_wr_addr;
    logic [31:0] o_wr_data, o_target, o_muldiv_upper, o_muldiv_bottom, rd_data;
    int failures = 0;
    int n_checks = 0;

    iex_datapath #(.DATA_W(32)) uut (.i_clk, .i_arst_n, .i_valid, .i_op,
        .i_source_a, .i_source_b, .i_dest, .i_shift_count, .i_jump_field,
        .i_offset, .i_branch_taken, .i_pc, .o_ready, .o_wr_en, .o_wr_addr,
        .o_wr_data, .o_overflow_trap, .o_redirect, .o_target,
        .o_muldiv_upper, .o_muldiv_bottom);
    iex_regfile_model u_rf (.i_clk(i_clk), .i_wr_en(o_wr_en),
        .i_wr_addr(o_wr_addr), .i_wr_data(o_wr_data), .i_rd_idx(i_dest),
        .o_rd_data(rd_data));

    initial begin
        forever #20 i_clk = ~i_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic issue(iex_op_t op, logic [31:0] a, logic [31:0] b);
        @(negedge i_clk);
        i_op = op;
        i_source_a = a;
        i_source_b = b;
        i_valid = 1'b1;
        @(posedge i_clk);
        @(negedge i_clk);
        i_valid = 1'b0;
    endtask
    task automatic flags(logic [2:0] f);
        chk({o_wr_en, o_overflow_trap, o_redirect}, f);
    endtask
    task automatic alu(iex_op_t op, logic [31:0] a, b, exp);
        issue(op, a, b);
        flags(3'b100);
        chk(o_wr_addr, i_dest);
        chk(o_wr_data, exp);
    endtask
    task automatic div(iex_op_t op, logic [31:0] a, b, logic [63:0] exp);
        int n;
        issue(op, a, b);
        n = 0;
        while (o_ready !== 1'b1 && n < 100) begin
            n++;
            @(negedge i_clk);
        end
        chk(n, 33);
        chk({o_muldiv_upper, o_muldiv_bottom}, exp);
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_alu;
        alu(OP_SUM_TRAP, 32'h5, 32'hffff_fffe, 32'h3);
        alu(OP_DIFF_TRAP, 32'h5, 32'h7, 32'hffff_fffe);
        alu(OP_SUM_NO_TRAP, 32'h7fff_ffff, 32'h1, 32'h8000_0000);
        alu(OP_DIFF_NO_TRAP, 32'h8000_0000, 32'h1, 32'h7fff_ffff);
        alu(OP_SET_IF_LESS_SIGNED, 32'hffff_ffff, 32'h1, 32'h1);
        alu(OP_SET_IF_BELOW_UNSIGNED, 32'hffff_ffff, 32'h1, 32'h0);
        alu(OP_AND, 32'hf0f0_ff00, 32'hff00_0ff0, 32'hf000_0f00);
        alu(OP_OR, 32'hf0f0_ff00, 32'hff00_0ff0, 32'hfff0_fff0);
        alu(OP_XOR, 32'hf0f0_ff00, 32'hff00_0ff0, 32'h0ff0_f0f0);
        alu(OP_NOR, 32'hf0f0_ff00, 32'hff00_0ff0, 32'h000f_000f);
        alu(OP_SHIFT_LEFT_FIXED, 32'h0, 32'h8000_0001,
            32'h8000_0000);
        alu(OP_SHIFT_RIGHT_ZERO_FIXED, 32'h0, 32'h8000_0001, 32'h1);
        alu(OP_SHIFT_RIGHT_SIGN_FIXED, 32'h0, 32'h8000_0001, '1);
        alu(OP_SHIFT_LEFT_VAR, 32'h24, 32'h8765_4321,
            32'h7654_3210);
        alu(OP_SHIFT_RIGHT_ZERO_VAR, 32'h24, 32'h8765_4321,
            32'h0876_5432);
        alu(OP_SHIFT_RIGHT_SIGN_VAR, 32'h24, 32'h8765_4321,
            32'hf876_5432);
        $display("alu test done");
    endtask
    task automatic t_trap;
        issue(OP_SUM_TRAP, 32'h7fff_ffff, 32'h1);
        flags(3'b010);
        issue(OP_DIFF_TRAP, 32'h8000_0000, 32'h1);
        flags(3'b010);
        $display("trap test done");
    endtask
    task automatic t_muldiv;
        issue(OP_SIGNED_PRODUCT, 32'hffff_fffe, 32'h3);
        flags(3'b000);
        chk({o_muldiv_upper, o_muldiv_bottom},
            64'hffff_ffff_ffff_fffa);
        issue(OP_UNSIGNED_PRODUCT, 32'hffff_ffff, 32'h2);
        chk({o_muldiv_upper, o_muldiv_bottom}, 64'h1_ffff_fffe);
        alu(OP_READ_UPPER, 32'h0, 32'h0, 32'h1);
        alu(OP_READ_BOTTOM, 32'h0, 32'h0, 32'hffff_fffe);
        @(negedge i_clk);
        chk(rd_data, 32'hffff_fffe);
        chk({o_muldiv_upper, o_muldiv_bottom}, 64'h1_ffff_fffe);
        issue(OP_WRITE_UPPER, 32'h1234_5678, 32'h0);
        chk(o_muldiv_upper, 32'h1234_5678);
        issue(OP_WRITE_BOTTOM, 32'h9abc_def0, 32'h0);
        chk({o_muldiv_upper, o_muldiv_bottom},
            64'h1234_5678_9abc_def0);
        div(OP_SIGNED_QUOTIENT, 32'hffff_fff9, 32'h2,
            64'hffff_ffff_ffff_fffd);
        div(OP_UNSIGNED_QUOTIENT, 32'h7, 32'h2, 64'h1_0000_0003);
        $display("muldiv test done");
    endtask
    task automatic t_jump;
        i_pc = 32'ha000_1000;
        i_jump_field = 26'h3ff_ffff;
        issue(OP_JUMP_ABSOLUTE, 32'h0, 32'h0);
        flags(3'b001);
        chk(o_target, 32'hafff_fffc);
        i_pc = 32'h5000_0010;
        i_jump_field = 26'h123_4567;
        issue(OP_CALL_ABSOLUTE_LINK, 32'h0, 32'h0);
        flags(3'b101);
        chk({o_wr_addr, o_wr_data}, {LINK_REG_IDX, 32'h5000_0018});
        chk(o_target, 32'h548d_159c);
        issue(OP_TRANSFER_VIA_REGISTER, 32'h1234_5678, 32'h0);
        flags(3'b001);
        chk(o_target, 32'h1234_5678);
        i_dest = 5'h07;
        issue(OP_CALL_VIA_REGISTER, 32'h0000_0400, 32'h0);
        flags(3'b101);
        chk(o_wr_addr, 5'h07);
        chk({o_wr_data, o_target}, 64'h5000_0018_0000_0400);
        i_offset = 16'hfffe;
        i_branch_taken = 1'b1;
        issue(OP_BRANCH, 32'h0, 32'h0);
        flags(3'b001);
        chk(o_target, 32'h5000_000c);
        i_branch_taken = 1'b0;
        issue(OP_BRANCH, 32'h0, 32'h0);
        flags(3'b000);
        issue(OP_BRANCH_LINK, 32'h0, 32'h0);
        flags(3'b100);
        chk(o_wr_addr, LINK_REG_IDX);
        chk({o_wr_data, o_target}, 64'h5000_0018_5000_000c);
        $display("jump test done");
    endtask

    initial begin
        repeat (5000) @(posedge i_clk);
        failures++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_arst_n = 1'b1;
        t_alu();
        t_trap();
        t_muldiv();
        t_jump();
        summarize();
    end
endmodule
`default_nettype wire
